/* File: rtl/rsmb_map.svh */
// constants of the rs-485 station front end
// ============================================================
`ifndef RSMB_MAP_SVH
`define RSMB_MAP_SVH
`define RSMB_CLK_HZ        100000000
`define RSMB_PROC_CYC      1000
`define RSMB_TICK_CYC      1000000
`define RSMB_ADDR_MAX      5'h1f
`define RSMB_PROTO_HL      3'h1
`define RSMB_PROTO_LH      3'h2
`define RSMB_PROTO_HOST    3'h5
`define RSMB_PARAM_LOCK_ID 9'h0a6
`endif

/* File: rtl/rsmb_pkg.sv */
// types of the rs-485 station front end
package rsmb_pkg;
  typedef enum logic [1:0] {
    RSMB_PAR_NONE = 2'h0,
    RSMB_PAR_EVEN = 2'h1,
    RSMB_PAR_ODD  = 2'h2
  } rsmb_par_t;
  typedef enum logic [2:0] {
    RSMB_RX_IDLE  = 3'h0,
    RSMB_RX_START = 3'h1,
    RSMB_RX_DATA  = 3'h2,
    RSMB_RX_PAR   = 3'h3,
    RSMB_RX_STOP  = 3'h4
  } rsmb_rx_t;
  typedef enum logic [2:0] {
    RSMB_TX_IDLE  = 3'h0,
    RSMB_TX_WAIT  = 3'h1,
    RSMB_TX_START = 3'h2,
    RSMB_TX_DATA  = 3'h3,
    RSMB_TX_PAR   = 3'h4,
    RSMB_TX_STOP  = 3'h5
  } rsmb_tx_t;
endpackage

/* File: rtl/rsmb_station.sv */
// rs-485 station front end: framing, address filter, reply timing, locks
`timescale 1ns/10ps
`default_nettype none
`include "rsmb_map.svh"
module rsmb_station #(
  parameter int TICK_CYC = `RSMB_TICK_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [4:0] station_address_setting_in,
  input  wire logic [2:0] bit_rate_select_in,
  input  wire logic [2:0] char_framing_select_in,
  input  wire logic [6:0] reply_delay_setting_in,
  input  wire logic [9:0] link_timeout_setting_in,
  input  wire logic [2:0] protocol_select_in,
  input  wire logic       param_write_lock_in,
  input  wire logic       posdata_write_lock_in,
  input  wire logic [53:0] ram_param_slot_in,
  input  wire logic [11:0] ram_posdata_slot_in,
  input  wire logic       rxd_in,
  input  wire logic       frame_end_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  input  wire logic       tx_last_in,
  input  wire logic [8:0] edit_param_id_in,
  input  wire logic       edit_param_req_in,
  input  wire logic       edit_posdata_req_in,
  output logic            edit_grant_out,
  output logic            edit_reject_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic            addr_match_out,
  output logic            parity_err_out,
  output logic            timeout_out,
  output logic            high_word_first_out,
  output logic            host_mode_out,
  output logic            modbus_mode_out,
  output logic [53:0]     ram_param_slot_out,
  output logic [11:0]     ram_posdata_slot_out,
  output logic            txd_out,
  output logic            txd_oe_out
);
  // ============================================================
  // power-on latched settings
  logic [4:0]  own_addr;
  logic [2:0]  rate_code;
  logic [2:0]  frame_code;
  logic        armed;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      own_addr             <= 5'h01;
      rate_code            <= 3'h0;
      frame_code           <= 3'h0;
      ram_param_slot_out   <= 54'h0;
      ram_posdata_slot_out <= 12'h0;
      armed                <= 1'b0;
    end else if (!armed) begin
      armed                <= 1'b1;
      own_addr             <= station_address_setting_in;
      rate_code            <= bit_rate_select_in;
      frame_code           <= (char_framing_select_in > 3'h5) ? 3'h0 :
                              char_framing_select_in;
      ram_param_slot_out   <= ram_param_slot_in;
      ram_posdata_slot_out <= ram_posdata_slot_in;
    end
  end
  // ============================================================
  // bit timing
  logic [16:0] bit_cyc;
  always_comb begin
    case (rate_code)
      3'h0:    bit_cyc = 17'd2604;
      3'h1:    bit_cyc = 17'd5208;
      3'h2:    bit_cyc = 17'd10417;
      3'h3:    bit_cyc = 17'd868;
      3'h4:    bit_cyc = 17'd1736;
      3'h5:    bit_cyc = 17'd20833;
      3'h6:    bit_cyc = 17'd41667;
      default: bit_cyc = 17'd83333;
    endcase
  end
  rsmb_pkg::rsmb_par_t par_mode;
  logic two_stop;
  always_comb begin
    case (frame_code)
      3'h0, 3'h3: par_mode = rsmb_pkg::RSMB_PAR_EVEN;
      3'h1, 3'h4: par_mode = rsmb_pkg::RSMB_PAR_ODD;
      default:    par_mode = rsmb_pkg::RSMB_PAR_NONE;
    endcase
    two_stop = frame_code >= 3'h3;
  end
  // char time in cycles: 1 start+8 data+parity+stops, at most 12 bits
  logic [3:0]  char_bits;
  logic [21:0] min_gap;
  assign char_bits = 4'h9 + {3'h0, par_mode != rsmb_pkg::RSMB_PAR_NONE} +
                     {3'h0, two_stop} + 4'h1;
  assign min_gap = 22'((22'(bit_cyc) * 22'(char_bits)) * 22'h3) +
                   22'(`RSMB_PROC_CYC);
  // ============================================================
  // receiver
  rsmb_pkg::rsmb_rx_t rx_st;
  logic [16:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_par;
  logic        first_byte;
  logic        frame_ok;
  logic        bcast;
  logic        rx_push;
  logic        rx_act;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_st <= rsmb_pkg::RSMB_RX_IDLE;
      rx_cnt <= 17'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h0;
      rx_par <= 1'b0;
      first_byte <= 1'b1;
      frame_ok <= 1'b0;
      bcast <= 1'b0;
      parity_err_out <= 1'b0;
      rx_push <= 1'b0;
      rx_act <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      rx_act <= 1'b0;
      if (frame_end_in) begin
        first_byte <= 1'b1;
      end
      case (rx_st)
        rsmb_pkg::RSMB_RX_IDLE: if (!rxd_in) begin
          rx_st <= rsmb_pkg::RSMB_RX_START;
          rx_cnt <= 17'(bit_cyc >> 1);
        end
        rsmb_pkg::RSMB_RX_START: if (rx_cnt == 17'h0) begin
          rx_st <= rxd_in ? rsmb_pkg::RSMB_RX_IDLE : rsmb_pkg::RSMB_RX_DATA;
          rx_cnt <= bit_cyc - 17'h1;
          rx_bit <= 3'h0;
          rx_par <= 1'b0;
        end else rx_cnt <= rx_cnt - 17'h1;
        rsmb_pkg::RSMB_RX_DATA: if (rx_cnt == 17'h0) begin
          rx_sh <= {rxd_in, rx_sh[7:1]};
          rx_par <= rx_par ^ rxd_in;
          rx_cnt <= bit_cyc - 17'h1;
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == 3'h7) begin
            rx_st <= (par_mode == rsmb_pkg::RSMB_PAR_NONE) ?
                     rsmb_pkg::RSMB_RX_STOP : rsmb_pkg::RSMB_RX_PAR;
          end
        end else rx_cnt <= rx_cnt - 17'h1;
        rsmb_pkg::RSMB_RX_PAR: if (rx_cnt == 17'h0) begin
          parity_err_out <= (rx_par ^ rxd_in) !=
                            (par_mode == rsmb_pkg::RSMB_PAR_ODD);
          rx_cnt <= bit_cyc - 17'h1;
          rx_st <= rsmb_pkg::RSMB_RX_STOP;
        end else rx_cnt <= rx_cnt - 17'h1;
        rsmb_pkg::RSMB_RX_STOP: if (rx_cnt == 17'h0) begin
          rx_st <= rsmb_pkg::RSMB_RX_IDLE;
          rx_act <= 1'b1;
          if (first_byte && !frame_end_in) begin
            first_byte <= 1'b0;
            // kept per frame: later bytes overwrite the shifter
            bcast <= rx_sh == 8'h00;
            // address 0 is broadcast: accepted but never answered
            frame_ok <= (rx_sh[4:0] == own_addr && rx_sh[7:5] == 3'h0) ||
                        rx_sh == 8'h00;
          end
          rx_push <= (first_byte ? ((rx_sh[4:0] == own_addr &&
                      rx_sh[7:5] == 3'h0) || rx_sh == 8'h00) : frame_ok) &&
                     !frame_end_in;
        end else rx_cnt <= rx_cnt - 17'h1;
        default: rx_st <= rsmb_pkg::RSMB_RX_IDLE;
      endcase
    end
  end
  assign addr_match_out = frame_ok;
  // ============================================================
  // two-entry receive buffer, stalls drop nothing while not full
  logic [7:0] rbuf [2];
  logic [1:0] rcount;
  logic       rpop;
  logic [1:0] next_rcount;
  assign rpop = rx_valid_out && rx_ready_in;
  always_comb begin
    next_rcount = rcount + 2'((rx_push && rcount != 2'h2) ? 1 : 0) -
                  2'(rpop ? 1 : 0);
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rcount <= 2'h0;
      rx_valid_out <= 1'b0;
      rbuf[0] <= 8'h0;
      rbuf[1] <= 8'h0;
    end else begin
      if (rpop) rbuf[0] <= rbuf[1];
      if (rx_push && rcount != 2'h2)
        rbuf[(rpop ? rcount - 2'h1 : rcount) == 2'h0 ? 0 : 1] <= rx_sh;
      rcount <= next_rcount;
      rx_valid_out <= next_rcount != 2'h0;
    end
  end
  assign rx_data_out = rbuf[0];
  // ============================================================
  // link timeout, ticked every 10 ms
  logic [19:0] tick_cnt;
  logic [9:0]  idle_ticks;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 20'h0;
      idle_ticks <= 10'h0;
      timeout_out <= 1'b0;
    end else if (rx_act || link_timeout_setting_in == 10'h0) begin
      tick_cnt <= 20'h0;
      idle_ticks <= 10'h0;
      timeout_out <= 1'b0;
    end else if (tick_cnt == 20'(TICK_CYC - 1)) begin
      tick_cnt <= 20'h0;
      if (idle_ticks + 10'h1 >= link_timeout_setting_in)
        timeout_out <= 1'b1;
      else idle_ticks <= idle_ticks + 10'h1;
    end else tick_cnt <= tick_cnt + 20'h1;
  end
  // ============================================================
  // protocol and edit locks
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      high_word_first_out <= 1'b1;
      host_mode_out <= 1'b0;
      modbus_mode_out <= 1'b0;
      edit_grant_out <= 1'b0;
      edit_reject_out <= 1'b0;
    end else begin
      high_word_first_out <= protocol_select_in != `RSMB_PROTO_LH;
      modbus_mode_out <= protocol_select_in == `RSMB_PROTO_HL ||
                         protocol_select_in == `RSMB_PROTO_LH;
      host_mode_out <= protocol_select_in == `RSMB_PROTO_HOST;
      edit_grant_out <= (edit_param_req_in && (!param_write_lock_in ||
                        edit_param_id_in == `RSMB_PARAM_LOCK_ID)) ||
                        (edit_posdata_req_in && !posdata_write_lock_in);
      edit_reject_out <= (edit_param_req_in && param_write_lock_in &&
                         edit_param_id_in != `RSMB_PARAM_LOCK_ID) ||
                         (edit_posdata_req_in && posdata_write_lock_in);
    end
  end
  // ============================================================
  // transmitter: waits the longer reply gap, then sends
  rsmb_pkg::rsmb_tx_t tx_st;
  logic [27:0] gap_cnt;
  logic [27:0] gap_need;
  logic [16:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_sh;
  logic        tx_par;
  logic        stop2;
  always_comb begin
    gap_need = 28'(reply_delay_setting_in) * 28'(TICK_CYC);
    if (gap_need < 28'(min_gap)) gap_need = 28'(min_gap);
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_st <= rsmb_pkg::RSMB_TX_IDLE;
      gap_cnt <= 28'h0;
      tx_cnt <= 17'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h0;
      tx_par <= 1'b0;
      stop2 <= 1'b0;
      tx_ready_out <= 1'b0;
      txd_out <= 1'b1;
      txd_oe_out <= 1'b0;
    end else begin
      tx_ready_out <= 1'b0;
      case (tx_st)
        rsmb_pkg::RSMB_TX_IDLE: begin
          txd_oe_out <= 1'b0;
          gap_cnt <= 28'h0;
          // broadcast and foreign frames get no reply
          if (frame_end_in && frame_ok && !bcast)
            tx_st <= rsmb_pkg::RSMB_TX_WAIT;
        end
        rsmb_pkg::RSMB_TX_WAIT: if (gap_cnt >= gap_need) begin
          if (tx_valid_in && !tx_ready_out) begin
            tx_ready_out <= 1'b1;
            tx_sh <= tx_data_in;
            tx_par <= ^tx_data_in;
            stop2 <= tx_last_in;
            tx_st <= rsmb_pkg::RSMB_TX_START;
            tx_cnt <= bit_cyc - 17'h1;
            txd_oe_out <= 1'b1;
            txd_out <= 1'b0;
          end
        end else gap_cnt <= gap_cnt + 28'h1;
        rsmb_pkg::RSMB_TX_START, rsmb_pkg::RSMB_TX_DATA:
          if (tx_cnt == 17'h0) begin
            tx_cnt <= bit_cyc - 17'h1;
            txd_out <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_bit <= (tx_st == rsmb_pkg::RSMB_TX_START) ? 3'h0 :
                      tx_bit + 3'h1;
            if (tx_st == rsmb_pkg::RSMB_TX_START)
              tx_st <= rsmb_pkg::RSMB_TX_DATA;
            else if (tx_bit == 3'h7) begin
              tx_st <= (par_mode == rsmb_pkg::RSMB_PAR_NONE) ?
                       rsmb_pkg::RSMB_TX_STOP : rsmb_pkg::RSMB_TX_PAR;
              txd_out <= (par_mode == rsmb_pkg::RSMB_PAR_NONE) ? 1'b1 :
                         tx_par ^ (par_mode == rsmb_pkg::RSMB_PAR_ODD);
              gap_cnt <= 28'(two_stop ? 2 : 1);
            end
          end else tx_cnt <= tx_cnt - 17'h1;
        rsmb_pkg::RSMB_TX_PAR: if (tx_cnt == 17'h0) begin
          tx_cnt <= bit_cyc - 17'h1;
          txd_out <= 1'b1;
          tx_st <= rsmb_pkg::RSMB_TX_STOP;
        end else tx_cnt <= tx_cnt - 17'h1;
        rsmb_pkg::RSMB_TX_STOP: if (tx_cnt == 17'h0) begin
          tx_cnt <= bit_cyc - 17'h1;
          // gap_cnt counts the stop bits still owed
          if (gap_cnt > 28'h1) gap_cnt <= gap_cnt - 28'h1;
          else begin
            gap_cnt <= gap_need;
            tx_st <= stop2 ? rsmb_pkg::RSMB_TX_IDLE : rsmb_pkg::RSMB_TX_WAIT;
          end
        end else tx_cnt <= tx_cnt - 17'h1;
        default: tx_st <= rsmb_pkg::RSMB_TX_IDLE;
      endcase
    end
  end
endmodule // rsmb_station
`default_nettype wire

/* File: sim/rsmb_properties.sv */
// checker of the station front end port behaviour
`timescale 1ns/10ps
`default_nettype none
module rsmb_station_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic [2:0]  protocol_select_in,
  input wire logic [9:0]  link_timeout_setting_in,
  input wire logic        param_write_lock_in,
  input wire logic        posdata_write_lock_in,
  input wire logic [8:0]  edit_param_id_in,
  input wire logic        edit_param_req_in,
  input wire logic        edit_posdata_req_in,
  input wire logic        edit_grant_out,
  input wire logic        edit_reject_out,
  input wire logic        timeout_out,
  input wire logic        high_word_first_out,
  input wire logic        host_mode_out,
  input wire logic        modbus_mode_out,
  input wire logic [53:0] ram_param_slot_out,
  input wire logic [11:0] ram_posdata_slot_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ============================================
  // edit locks
  property p_par_rej;
    edit_param_req_in && param_write_lock_in && edit_param_id_in != 9'h0a6
      |=> edit_reject_out && !edit_grant_out;
  endproperty
  a_par_rej: assert property (p_par_rej)
    else $error("locked parameter edit granted");
  property p_par_ok;
    edit_param_req_in && (!param_write_lock_in || edit_param_id_in == 9'h0a6)
      |=> edit_grant_out && !edit_reject_out;
  endproperty
  a_par_ok: assert property (p_par_ok)
    else $error("open parameter edit refused");
  property p_pos_rej;
    edit_posdata_req_in && posdata_write_lock_in |=> edit_reject_out;
  endproperty
  a_pos_rej: assert property (p_pos_rej)
    else $error("locked positioning edit granted");
  // ============================================
  // protocol modes, timeout, latched slots
  property p_hl;
    (protocol_select_in == 3'h1) [*3] |-> modbus_mode_out && high_word_first_out;
  endproperty
  a_hl: assert property (p_hl)
    else $error("high word order missing");
  property p_lh;
    (protocol_select_in == 3'h2) [*3] |-> modbus_mode_out && !high_word_first_out;
  endproperty
  a_lh: assert property (p_lh)
    else $error("low word order missing");
  property p_host;
    (protocol_select_in == 3'h5) [*3] |-> host_mode_out && !modbus_mode_out;
  endproperty
  a_host: assert property (p_host)
    else $error("host mode missing");
  property p_tmo_off;
    (link_timeout_setting_in == 10'h000) [*3] |-> !timeout_out;
  endproperty
  a_tmo_off: assert property (p_tmo_off)
    else $error("timeout while disabled");
  property p_latch;
    $past(rst_b_in) |=> $stable(ram_param_slot_out) && $stable(ram_posdata_slot_out);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched slot changed without reset");
endmodule // rsmb_station_chk
`default_nettype wire

/* File: sim/rsmb_master_model.sv */
// serial master putting request characters on the line
`timescale 1ns/10ps
`default_nettype none
module rsmb_master_model #(
  parameter int BIT_CYC = 868
) (
  input  wire logic       clk_in,
  input  wire logic [2:0] framing_in,
  output logic            rxd_out
);
  // ============================================
  // character sender
  initial rxd_out = 1'b1; // biased line idles high
  task automatic send(input logic [7:0] b);
    logic [11:0] f;
    logic        pe;
    pe = !(framing_in == 3'h2 || framing_in == 3'h5);
    f = {3'h7, pe ? ^b ^ (framing_in % 3 == 1) : 1'b1, b, 1'b0};
    for (int i = 0; i < 10 + pe + (framing_in > 3'h2); i++) begin
      rxd_out = f[i];
      repeat (BIT_CYC) @(posedge clk_in);
      #1;
    end
  endtask
endmodule // rsmb_master_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench of the rs-485 station front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int BIT = 868; // rate code 3 at 100 MHz
  localparam int MINW = 30 * BIT + 1000; // three 10-bit chars plus work
  logic core_clk_in = 0, rst_b_in = 0, rxd_in, frame_end_in = 0;
  logic tx_valid_in = 0, tx_last_in = 1, rx_ready_in = 0;
  logic edit_param_req_in = 0, edit_posdata_req_in = 0;
  logic param_write_lock_in = 0, posdata_write_lock_in = 0;
  logic [4:0] station_address_setting_in = 5'h01;
  logic [2:0] bit_rate_select_in = 3'h3, char_framing_select_in = 3'h0;
  logic [2:0] protocol_select_in = 3'h1;
  logic [6:0] reply_delay_setting_in = 7'h00;
  logic [9:0] link_timeout_setting_in = 10'h000;
  logic [53:0] ram_param_slot_in = 54'h0, ram_param_slot_out;
  logic [11:0] ram_posdata_slot_in = 12'h0, ram_posdata_slot_out;
  logic [7:0] tx_data_in = 8'h00, rx_data_out;
  logic [8:0] edit_param_id_in = 9'h000;
  logic tx_ready_out, edit_grant_out, edit_reject_out, rx_valid_out;
  logic addr_match_out, parity_err_out, timeout_out, txd_out, txd_oe_out;
  logic high_word_first_out, host_mode_out, modbus_mode_out;
  int seed = 32'h60cd7f8f;
  int errors = 0;
  int num_checks = 0;
  int cnt;
  logic [31:0] r;
  logic [63:0] sl;
  logic [7:0] d [3];
  logic [2:0] m;
  logic [2:0] pl [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  rsmb_station #(.TICK_CYC(100)) rsmb_station_inst (.*);
  rsmb_master_model #(.BIT_CYC(BIT)) rsmb_master_model_inst (
    .clk_in(core_clk_in),
    .framing_in(char_framing_select_in),
    .rxd_out(rxd_in)
  );
  // ============================================
  // clock, helpers
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (tx_ready_out) tx_valid_in <= 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input string nm, input logic [63:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait: 0 rx byte, 1 line driven, 2 timeout
  task automatic wait_on(input int w, lim);
    cnt = 0;
    while (cnt < lim && !(w == 0 ? rx_valid_out : w == 1 ? txd_oe_out
                          : timeout_out)) begin
      tick(1);
      cnt++;
    end
    if (cnt == lim) begin
      errors++;
      $display("unexpected wait %0d expected 1 seen 0", w);
      end_sim;
    end
  endtask
  function automatic logic [1:0] exp_edit(input logic pos, lk,
                                          input logic [8:0] id);
    return (lk && (pos || id != 9'h0a6)) ? 2'b01 : 2'b10;
  endfunction
  function automatic logic [2:0] exp_mode(input logic [2:0] p);
    return {p == 3'h1 || p == 3'h2, p == 3'h5, p != 3'h2};
  endfunction
  // ============================================
  // main sequence
  initial begin
    for (int c = 0; c < 6; c++) begin
      char_framing_select_in = 3'(c);
      station_address_setting_in = 5'h01 + 5'($unsigned($random(seed)) % 31);
      sl = {$random(seed), $random(seed)};
      ram_param_slot_in = sl[53:0];
      ram_posdata_slot_in = sl[63:52];
      rst_b_in = 0;
      tick(10);
      rst_b_in = 1;
      tick(2);
      ram_param_slot_in = ~sl[53:0];
      ram_posdata_slot_in = ~sl[63:52];
      tick(2);
      check("ram_param", ram_param_slot_out, sl[53:0]);
      check("ram_pos", ram_posdata_slot_out, sl[63:52]);
      d[0] = {3'h0, station_address_setting_in} ^ (c == 5 ? 8'h20 : 8'h00);
      d[1] = 8'($random(seed));
      d[2] = 8'($random(seed));
      // receiver stalls: third byte of three must be dropped
      for (int i = 0; i < (c == 2 ? 3 : 1); i++) rsmb_master_model_inst.send(d[i]);
      if (c == 5) begin
        tick(2 * BIT);
        check("foreign", {addr_match_out, rx_valid_out, txd_oe_out}, 0);
      end else begin
        for (int i = 0; i < (c == 2 ? 2 : 1); i++) begin
          wait_on(0, 100);
          check("rx_data", rx_data_out, d[i]);
          check("flags", {addr_match_out, parity_err_out}, 2'b10);
          rx_ready_in = 1;
          tick(1);
          rx_ready_in = 0;
        end
        tick(3);
        check("rx_empty", rx_valid_out, 0);
      end
      if (c == 2) begin
        reply_delay_setting_in = 7'($unsigned($random(seed)) % 101);
        frame_end_in = 1;
        tick(1);
        frame_end_in = 0;
        tx_data_in = d[1] ^ 8'h5a;
        tx_valid_in = 1;
        wait_on(1, 40000);
        check("reply_wait", cnt >= MINW - 2 && cnt <= MINW + 500, 1);
        tick(BIT / 2);
        check("start", txd_out, 0);
        for (int i = 0; i < 8; i++) begin
          tick(BIT);
          check("txd", txd_out, tx_data_in[i]);
        end
        tick(BIT);
        check("stop", txd_out, 1);
        tick(2 * BIT);
        check("release", txd_oe_out, 0);
      end
      $display("framing %0d done", c);
    end
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      param_write_lock_in = r[0];
      posdata_write_lock_in = r[1];
      edit_param_id_in = r[2] ? 9'h0a6 : r[12:4];
      edit_param_req_in = !r[3];
      edit_posdata_req_in = r[3];
      tick(1);
      edit_param_req_in = 0;
      edit_posdata_req_in = 0;
      check("edit", {edit_grant_out, edit_reject_out},
            exp_edit(r[3], r[3] ? r[1] : r[0], edit_param_id_in));
      tick(1);
    end
    foreach (pl[k]) begin
      protocol_select_in = pl[k];
      tick(3);
      m = exp_mode(pl[k]);
      check("mode", {modbus_mode_out, host_mode_out}, m[2:1]);
      if (m[2]) check("order", high_word_first_out, m[0]);
    end
    $display("edits and modes done");
    link_timeout_setting_in = 10'h001;
    wait_on(2, 400);
    check("timeout", timeout_out, 1);
    link_timeout_setting_in = 10'h000;
    tick(3);
    check("timeout_off", timeout_out, 0);
    end_sim;
  end
endmodule // tb_top
bind rsmb_station rsmb_station_chk rsmb_station_chk_inst (.*);
`default_nettype wire
